// *** inc/spc_pkg.sv ***
// Package of constants and types for the synthesiser self-calibration and power controller.
package spc_pkg;

  // Width of one tuning value: oscillator tuning word and charge-pump current word.
  localparam int SPC_OSC_W = 6;
  localparam int SPC_PUMP_W = 4;

  // Reset value of stored tuning words.
  localparam logic [5:0] SPC_OSC_RST = 6'h20;
  localparam logic [3:0] SPC_PUMP_RST = 4'h8;

  // Pin source select field width and the codes this block serves.
  localparam int SPC_SEL_W = 4;
  localparam logic [3:0] SPC_SEL_LOW = 4'h0;
  localparam logic [3:0] SPC_SEL_LOCK = 4'h1;
  localparam logic [3:0] SPC_SEL_CAL_DONE = 4'h2;
  localparam logic [3:0] SPC_SEL_HIGH = 4'h3;

  // Signal strength select codes; zero switches the function off.
  localparam logic [1:0] SPC_RSSI_OFF = 2'h0;

  // Worst-case calibration time in ms at the lowest reference rate of 1 MHz.
  localparam int SPC_CAL_MS = 34;
  localparam int SPC_REF_MIN_KHZ = 1000;
  // Reference cycles in a calibration: time times rate, a fixed count, so the time scales inversely with the reference.
  localparam int SPC_CAL_REF_CYCLES = SPC_CAL_MS * SPC_REF_MIN_KHZ;
  // Reference divider range.
  localparam logic [3:0] SPC_REFDIV_MIN = 4'h2;

  // Calibration sequencer states, one-hot.
  typedef enum logic [3:0] {
    SPC_IDLE = 4'b0001,
    SPC_RUN = 4'b0010,
    SPC_DONE = 4'b0100,
    SPC_WAIT_CLR = 4'b1000
  } spc_state_t;

endpackage

// *** src/spc_ref_tick.sv ***
// Reference clock tick generator: divides the core clock by the programmed reference divider.
`timescale 1ns/100ps
module spc_ref_tick
  import spc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] ref_div,
  output logic ref_tick
);

  // Cycle counter within one reference period.
  logic [3:0] count;
  // Divider clamped so that illegal values still give a legal period.
  logic [3:0] div_eff;

  // Values below the legal minimum behave as the minimum.
  always_comb
  begin
    div_eff = (ref_div < SPC_REFDIV_MIN) ? SPC_REFDIV_MIN : ref_div;
  end

  // Counter wraps every div_eff cycles; a divider change takes effect at once, within the current period.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      count <= 4'h0;
    end
    else if (count >= div_eff - 4'h1)
    begin
      count <= 4'h0;
    end
    else
    begin
      count <= count + 4'h1;
    end
  end

  // Tick is a registered one-cycle pulse at each wrap.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ref_tick <= 1'b0;
    end
    else
    begin
      ref_tick <= (count >= div_eff - 4'h1);
    end
  end

endmodule

// *** src/spc_tune_store.sv ***
// Two-entry store of calibration results, one entry per frequency word.
`timescale 1ns/100ps
module spc_tune_store
  import spc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic wr_both,
  input wire logic wr_word,
  input wire logic [5:0] wr_osc,
  input wire logic [3:0] wr_pump,
  input wire logic rd_word,
  output logic [5:0] rd_osc,
  output logic [3:0] rd_pump
);

  // One entry per frequency word.
  logic [5:0] osc_mem [2];
  logic [3:0] pump_mem [2];

  // Writes store the result; shared mode fills both entries at once.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      osc_mem[0] <= SPC_OSC_RST;
      osc_mem[1] <= SPC_OSC_RST;
      pump_mem[0] <= SPC_PUMP_RST;
      pump_mem[1] <= SPC_PUMP_RST;
    end
    else if (wr_en)
    begin
      if (wr_both || !wr_word)
      begin
        osc_mem[0] <= wr_osc;
        pump_mem[0] <= wr_pump;
      end
      if (wr_both || wr_word)
      begin
        osc_mem[1] <= wr_osc;
        pump_mem[1] <= wr_pump;
      end
    end
  end

  // Read data are registered, one cycle after the select.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rd_osc <= SPC_OSC_RST;
      rd_pump <= SPC_PUMP_RST;
    end
    else
    begin
      rd_osc <= osc_mem[rd_word];
      rd_pump <= pump_mem[rd_word];
    end
  end

endmodule

// *** src/spc_ctrl.sv ***
// Synthesiser self-calibration sequencer, tuning result handling and power-down controls.
//
// Contract
// RULE_01 - Host sets frequency before starting calibration.
// RULE_02 - Calibration result held while power applied.
// RULE_03 - Completion flag raised; timed wait covers worst case.
// RULE_04 - Calibration time scales inversely with reference rate.
// RULE_05 - Completion flag selectable onto status output pin.
// RULE_06 - Host clears start bit after completion.
// RULE_07 - Separate calibration values per frequency word.
// RULE_08 - Host calibrates words separately when far apart.
// RULE_09 - Dual bit selects shared or separate calibration.
// RULE_10 - Result readable through two readback values.
// RULE_11 - Readback follows selected word in separate mode.
// RULE_12 - Force values used when both overrides set.
// RULE_13 - Independent power-down bits for four sections.
// RULE_14 - Host zeroes output power before power-down.
// RULE_15 - Host leaves latch line high during power-down.
// RULE_16 - Signal strength select gates shared output function.
// RULE_17 - Select bit picks word A or B.
// RULE_18 - Pin source field chooses status pin function.
// RULE_19 - Flag holds until start clears; new start needs edge.
// RULE_20 - Wait timer counts reference clock cycles.
`timescale 1ns/100ps
module spc_ctrl
  import spc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cal_start,
  input wire logic cal_dual,
  input wire logic cal_wait,
  input wire logic freq_word_sel,
  input wire logic [3:0] ref_div,
  input wire logic [5:0] osc_tune_meas,
  input wire logic [3:0] pump_tune_meas,
  input wire logic pll_lock,
  input wire logic [3:0] pin_source_sel,
  input wire logic [1:0] signal_strength_out_sel,
  input wire logic [5:0] tune_force_first,
  input wire logic oscillator_force_enable,
  input wire logic [3:0] tune_force_second,
  input wire logic pump_force_enable,
  input wire logic rx_power_down,
  input wire logic tx_power_down,
  input wire logic synth_power_down,
  input wire logic xosc_power_down,
  output logic cal_complete,
  output logic cal_busy,
  output logic status_output_pin,
  output logic [5:0] tune_readback_first,
  output logic [3:0] tune_readback_second,
  output logic [5:0] osc_tune_apply,
  output logic [3:0] pump_tune_apply,
  output logic synth_word_b,
  output logic rx_enable,
  output logic tx_enable,
  output logic synth_enable,
  output logic xosc_enable,
  output logic signal_strength_enable
);

  // Start bit after the two-stage synchroniser; first stage feeds only the second.
  logic start_meta;
  logic start_sync;
  // Previous synchronised start, for rising edge detection.
  logic start_prev;
  logic start_rise;
  // Sequencer state and its next value.
  spc_state_t state;
  spc_state_t next_state;
  // Reference tick from the divider.
  logic ref_tick;
  // Reference cycles counted during a calibration.
  logic [15:0] ref_count;
  // Word being calibrated, latched at start.
  logic cal_word;
  // Shared-mode choice latched at start so a mid-run change has no effect.
  logic cal_shared;
  // Store write strobe and stored values for the selected word.
  logic store_wr;
  logic [5:0] stored_osc;
  logic [3:0] stored_pump;

  // Reference tick generator: the timer runs on reference periods, not core cycles.
  spc_ref_tick u_ref_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ref_div(ref_div),
    .ref_tick(ref_tick)
  );

  // Start bit arrives from the serial interface domain, so it is synchronised.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
    end
    else
    begin
      start_meta <= cal_start;
      start_sync <= start_meta;
    end
  end

  // Edge history of the synchronised start bit.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      start_prev <= 1'b0;
    end
    else
    begin
      start_prev <= start_sync;
    end
  end

  // Only a fresh rising start launches a run; a held start does not retrigger.
  assign start_rise = start_sync && !start_prev; // RULE_19

  // Next-state logic of the calibration sequencer.
  always_comb
  begin
    next_state = state;
    unique case (state)
      SPC_IDLE:
      begin
        if (start_rise)
        begin
          next_state = SPC_RUN; // RULE_01
        end
      end
      SPC_RUN:
      begin
        // Run length is a fixed count of reference periods, so shorter at faster rates.
        if (ref_tick && ref_count == 16'(SPC_CAL_REF_CYCLES - 1))
        begin
          next_state = SPC_DONE; // RULE_04
        end
      end
      SPC_DONE:
      begin
        next_state = SPC_WAIT_CLR;
      end
      SPC_WAIT_CLR:
      begin
        // Flag holds here until the host drops the start bit.
        if (!start_sync)
        begin
          next_state = SPC_IDLE; // RULE_19
        end
      end
      default:
      begin
        next_state = SPC_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= SPC_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Reference period counter, cleared at the start of each run.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ref_count <= 16'h0000;
    end
    else if (state != SPC_RUN)
    begin
      ref_count <= 16'h0000;
    end
    else if (ref_tick)
    begin
      ref_count <= ref_count + 16'h0001; // RULE_20
    end
  end

  // Latch target word and mode at launch.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cal_word <= 1'b0;
      cal_shared <= 1'b0;
    end
    else if (state == SPC_IDLE && start_rise)
    begin
      cal_word <= freq_word_sel;
      cal_shared <= cal_dual; // RULE_09
    end
  end

  // The result is written once, at the end of a run.
  assign store_wr = (state == SPC_DONE);

  // Results persist until reset, which stands in for loss of power.
  spc_tune_store u_store (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(store_wr), // RULE_02
    .wr_both(cal_shared), // RULE_09
    .wr_word(cal_word), // RULE_07
    .wr_osc(osc_tune_meas),
    .wr_pump(pump_tune_meas),
    .rd_word(freq_word_sel), // RULE_11
    .rd_osc(stored_osc),
    .rd_pump(stored_pump)
  );

  // Completion flag is set at the end of a run and cleared only with the start bit.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cal_complete <= 1'b0;
      cal_busy <= 1'b0;
    end
    else
    begin
      cal_complete <= (next_state == SPC_DONE) || (next_state == SPC_WAIT_CLR); // RULE_03
      cal_busy <= (next_state == SPC_RUN);
    end
  end

  // Readback shows the stored result of the selected word.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tune_readback_first <= SPC_OSC_RST;
      tune_readback_second <= SPC_PUMP_RST;
    end
    else
    begin
      tune_readback_first <= stored_osc; // RULE_10
      tune_readback_second <= stored_pump; // RULE_10
    end
  end

  // Applied tuning: forced values only when both overrides are set together.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      osc_tune_apply <= SPC_OSC_RST;
      pump_tune_apply <= SPC_PUMP_RST;
    end
    else if (oscillator_force_enable && pump_force_enable)
    begin
      osc_tune_apply <= tune_force_first; // RULE_12
      pump_tune_apply <= tune_force_second; // RULE_12
    end
    else
    begin
      osc_tune_apply <= stored_osc;
      pump_tune_apply <= stored_pump;
    end
  end

  // Status pin mux; unknown codes drive low so the pin never floats.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      status_output_pin <= 1'b0;
    end
    else
    begin
      case (pin_source_sel) // RULE_18
        SPC_SEL_LOCK: status_output_pin <= pll_lock;
        SPC_SEL_CAL_DONE: status_output_pin <= cal_complete; // RULE_05
        SPC_SEL_HIGH: status_output_pin <= 1'b1;
        default: status_output_pin <= 1'b0;
      endcase
    end
  end

  // Word select, power-down decode and signal strength enable; the host's
  // power-level and latch-line duties are outside this logic.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      synth_word_b <= 1'b0;
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      synth_enable <= 1'b0;
      xosc_enable <= 1'b0;
      signal_strength_enable <= 1'b0;
    end
    else
    begin
      synth_word_b <= freq_word_sel; // RULE_17
      rx_enable <= !rx_power_down; // RULE_13
      tx_enable <= !tx_power_down; // RULE_13
      synth_enable <= !synth_power_down; // RULE_13
      xosc_enable <= !xosc_power_down; // RULE_13
      signal_strength_enable <= (signal_strength_out_sel != SPC_RSSI_OFF); // RULE_16
    end
  end

endmodule

// *** test/spc_host_model.sv ***
// Host model: starts one calibration, polls the flag, then clears the start bit.
`timescale 1ns/100ps
module spc_host_model
#(
  parameter int CLR_DELAY = 20
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic cal_complete,
  output logic cal_start
);
  // Polls this long before clearing, so the flag is seen to stand.
  int wait_cnt;

  // The bench sets the frequency word before it raises go; one process owns the start bit.
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cal_start <= 1'b0;
      wait_cnt <= 0;
    end
    else if (go && !cal_start && !cal_complete)
    begin
      // The poll count restarts with every run, so a later run waits as long.
      cal_start <= 1'b1;
      wait_cnt <= 0;
    end
    else if (cal_complete && cal_start)
    begin
      // A slow host keeps start high for a while after completion.
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= CLR_DELAY)
        cal_start <= 1'b0;
    end
  end
endmodule

// *** test/spc_ctrl_props.sv ***
// Concurrent checks on the ports of the calibration and power controller.
`timescale 1ns/100ps
module spc_ctrl_chk
  import spc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cal_start,
  input wire logic freq_word_sel,
  input wire logic pll_lock,
  input wire logic [3:0] pin_source_sel,
  input wire logic [1:0] signal_strength_out_sel,
  input wire logic [5:0] tune_force_first,
  input wire logic oscillator_force_enable,
  input wire logic [3:0] tune_force_second,
  input wire logic pump_force_enable,
  input wire logic rx_power_down,
  input wire logic xosc_power_down,
  input wire logic cal_complete,
  input wire logic cal_busy,
  input wire logic status_output_pin,
  input wire logic [5:0] osc_tune_apply,
  input wire logic [3:0] pump_tune_apply,
  input wire logic synth_word_b,
  input wire logic rx_enable,
  input wire logic xosc_enable,
  input wire logic signal_strength_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_pwr;
    1 |=> rx_enable == !$past(rx_power_down) && xosc_enable == !$past(xosc_power_down);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power enable mismatch");
  property p_pin_done;
    pin_source_sel == SPC_SEL_CAL_DONE |=> status_output_pin == $past(cal_complete);
  endproperty
  a_pin_done: assert property (p_pin_done) else $error("pin not showing done");
  property p_pin_lock;
    pin_source_sel == SPC_SEL_LOCK |=> status_output_pin == $past(pll_lock);
  endproperty
  a_pin_lock: assert property (p_pin_lock) else $error("pin not showing lock");
  property p_pin_hi;
    pin_source_sel == SPC_SEL_HIGH |=> status_output_pin;
  endproperty
  a_pin_hi: assert property (p_pin_hi) else $error("pin not high");
  property p_rssi;
    1 |=> signal_strength_enable == ($past(signal_strength_out_sel) != SPC_RSSI_OFF);
  endproperty
  a_rssi: assert property (p_rssi) else $error("strength enable wrong");
  property p_word;
    1 |=> synth_word_b == $past(freq_word_sel);
  endproperty
  a_word: assert property (p_word) else $error("word select wrong");
  property p_force;
    (oscillator_force_enable && pump_force_enable && $stable(tune_force_first) && $stable(tune_force_second))[*3]
      |-> osc_tune_apply == tune_force_first && pump_tune_apply == tune_force_second;
  endproperty
  a_force: assert property (p_force) else $error("force not applied");
  property p_end;
    $fell(cal_busy) |-> cal_complete;
  endproperty
  a_end: assert property (p_end) else $error("run ended without flag");
  property p_hold;
    cal_complete && cal_start && $past(cal_start) && $past(cal_start, 2) |=> cal_complete && !cal_busy;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped or rerun");
  property p_run;
    $rose(cal_busy) |-> !cal_complete ##1 cal_busy[*8];
  endproperty
  a_run: assert property (p_run) else $error("run too short");

  c_done: cover property ($rose(cal_complete));
  c_pin: cover property (pin_source_sel == SPC_SEL_CAL_DONE && status_output_pin);
  c_force: cover property (oscillator_force_enable && pump_force_enable);
endmodule

bind spc_ctrl spc_ctrl_chk u_spc_ctrl_chk (.*);

// *** test/tb_top.sv ***
// Self-checking bench for the calibration and power controller.
`timescale 1ns/100ps
module tb_top;
  import spc_pkg::*;
  logic core_clk, rst_n, cal_start, cal_dual, cal_wait, freq_word_sel, pll_lock, go;
  logic oscillator_force_enable, pump_force_enable;
  logic rx_power_down, tx_power_down, synth_power_down, xosc_power_down;
  logic [3:0] ref_div, pump_tune_meas, pin_source_sel, tune_force_second;
  logic [5:0] osc_tune_meas, tune_force_first;
  logic [1:0] signal_strength_out_sel;
  logic cal_complete, cal_busy, status_output_pin, synth_word_b;
  logic rx_enable, tx_enable, synth_enable, xosc_enable, signal_strength_enable;
  logic [5:0] tune_readback_first, osc_tune_apply;
  logic [3:0] tune_readback_second, pump_tune_apply;
  logic [31:0] r, q;
  // Host-side settings that the block never sees, kept as the host would before power-down.
  logic [7:0] output_power_level;
  logic program_latch_enable;
  integer seed = 78719;
  int num_errors = 0;
  int compares = 0;
  int cyc;

  spc_ctrl u_spc_ctrl (.*);
  spc_host_model u_spc_host_model (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .go(go),
    .cal_complete(cal_complete),
    .cal_start(cal_start)
  );

  // Clock at 40 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Counts every comparison and reports a mismatch at once.
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Expected status pin level for a source code.
  function automatic logic exp_pin(input logic [3:0] s, input logic lk);
    return (s == SPC_SEL_LOCK) ? lk : (s == SPC_SEL_HIGH);
  endfunction

  // Stored tuning of a word: only word B was calibrated, on its own, so word A keeps reset values.
  function automatic logic [9:0] exp_tune(input logic w);
    return w ? {6'h15, 4'h3} : {SPC_OSC_RST, SPC_PUMP_RST};
  endfunction

  // Applied tuning: the force values only when both override bits are set.
  function automatic logic [9:0] exp_apply(input logic w);
    return (oscillator_force_enable && pump_force_enable) ? {tune_force_first, tune_force_second} : exp_tune(w);
  endfunction

  // One random vector, held long enough for the two-cycle paths.
  task rand_step;
    @(posedge core_clk);
    r = $random(seed);
    q = $random(seed);
    {freq_word_sel, pll_lock, cal_dual, cal_wait} <= r[3:0];
    {oscillator_force_enable, pump_force_enable} <= (r[4] ? 2'h3 : r[6:5]);
    {rx_power_down, tx_power_down, synth_power_down, xosc_power_down} <= r[10:7];
    // Any section going down finds the output power zeroed and the latch line parked high.
    output_power_level <= (|r[10:7]) ? 8'h00 : q[17:10];
    program_latch_enable <= (|r[10:7]) ? 1'b1 : q[18];
    pin_source_sel <= r[14:11];
    signal_strength_out_sel <= r[16:15];
    tune_force_first <= r[22:17];
    tune_force_second <= r[26:23];
    ref_div <= r[30:27];
    osc_tune_meas <= q[5:0];
    pump_tune_meas <= q[9:6];
    repeat (3) @(posedge core_clk);
    #1;
    check(status_output_pin, exp_pin(pin_source_sel, pll_lock));
    check(signal_strength_enable, signal_strength_out_sel != SPC_RSSI_OFF);
    check(synth_word_b, freq_word_sel);
    // The concatenation keeps the inversion at four bits.
    check({rx_enable, tx_enable, synth_enable, xosc_enable}, {~r[10:7]});
    // The separate run filled only word B, so the selection decides what is read.
    check({tune_readback_first, tune_readback_second}, exp_tune(freq_word_sel));
    check({osc_tune_apply, pump_tune_apply}, exp_apply(freq_word_sel));
  endtask

  // Cuts a hang short well past one full calibration.
  initial
  begin
    #(80000 * 25);
    num_errors++;
    end_sim();
  end

  initial
  begin
    {rst_n, go, freq_word_sel, pll_lock, cal_wait, oscillator_force_enable, pump_force_enable} = '0;
    {rx_power_down, tx_power_down, synth_power_down, xosc_power_down} = '0;
    {signal_strength_out_sel, tune_force_first, tune_force_second} = '0;
    cal_dual = 1'b0;
    ref_div = 4'h2;
    osc_tune_meas = 6'h15;
    pump_tune_meas = 4'h3;
    pin_source_sel = SPC_SEL_CAL_DONE;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check({tune_readback_first, tune_readback_second}, {SPC_OSC_RST, SPC_PUMP_RST});
    check({cal_complete, cal_busy}, 2'h0);
    // Word B is chosen first and then calibrated on its own.
    @(posedge core_clk);
    freq_word_sel <= 1'b1;
    @(posedge core_clk);
    cal_wait <= 1'b1;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    cyc = 0;
    while (cal_complete !== 1'b1 && cyc < 70000)
    begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    // Run length is 34000 reference periods of ref_div core cycles.
    check(cyc >= 2 * SPC_CAL_REF_CYCLES && cyc <= 2 * SPC_CAL_REF_CYCLES + 12, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    check({cal_complete, status_output_pin, cal_busy}, 3'h6);
    cyc = 0;
    while (cal_complete === 1'b1 && cyc < 40)
    begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    check(cyc > 15 && cyc < 40, 1'b1);
    repeat (10) @(posedge core_clk);
    #1;
    check({cal_complete, cal_busy}, 2'h0);
    check({tune_readback_first, tune_readback_second}, exp_tune(1'b1));
    repeat (40) rand_step();
    end_sim();
  end
endmodule
